// [logic/mtp_pkg.sv]
// package: register map, encodings and reset values for the mode and trim bank
`default_nettype none
package mtp_pkg;
  // register byte offsets
  localparam logic [7:0] REG_SPECIAL_FUNC = 8'h00;
  localparam logic [7:0] REG_RANGE_TYPE   = 8'h04;
  localparam logic [7:0] REG_VIS_MASK     = 8'h08;
  localparam logic [7:0] REG_CONFIG       = 8'h0C;
  localparam logic [7:0] REG_MODES        = 8'h10;
  localparam logic [7:0] REG_TRIM         = 8'h14;
  localparam logic [7:0] REG_TRIM_CTRL    = 8'h18;
  localparam logic [7:0] REG_STATUS       = 8'h1C;
  // special function
  localparam logic [3:0] SFC_RESET        = 4'h0;
  localparam logic [3:0] SFC_TRIM_ENABLE  = 4'h5;
  // resistance-thermometer range types
  localparam logic [7:0] RTD_LO_A         = 8'd41;
  localparam logic [7:0] RTD_HI_A         = 8'd52;
  localparam logic [7:0] RTD_LO_B         = 8'd63;
  localparam logic [7:0] RTD_HI_B         = 8'd68;
  localparam logic [7:0] RANGE_RESET      = 8'd0;
  // trim in centi-ohm, signed 16 bit
  localparam logic signed [15:0] TRIM_RESET = 16'sh0000;
  localparam logic signed [15:0] TRIM_LIMIT = 16'sd2000;
  localparam logic signed [15:0] TRIM_SHOWN_MIN = -16'sd1999;
  // mode bits and visibility mask bits
  localparam int BIT_AM  = 0;
  localparam int BIT_RR  = 1;
  localparam int BIT_SPS = 2;
  localparam logic [2:0] MODES_RESET      = 3'b000;
  localparam logic [7:0] VIS_MASK_RESET   = 8'hFF;
  // config bits: [2:0] contact assign, [3] control method, [4] remote capable
  localparam int CFG_CTRL_METHOD = 3;
  localparam int CFG_REMOTE_CAP  = 4;
  localparam logic [4:0] CONFIG_RESET     = 5'b0_1000;
  // trim control: bit 0 enter key
  localparam int TCTL_ENTER = 0;
  typedef enum logic [1:0] {TRIM_IDLE, TRIM_SHOWN} mtp_trim_state_t;
endpackage : mtp_pkg
`default_nettype wire

// [logic/mtp_access.sv]
// access gates: which parameters are visible and which are settable
`default_nettype none
module mtp_access
  import mtp_pkg::*;
(
  input  wire logic [7:0] range_type,
  input  wire logic [3:0] special_func,
  input  wire logic [7:0] vis_mask,
  input  wire logic [4:0] config_bits,
  output logic      [2:0] mode_visible,
  output logic      [2:0] mode_settable,
  output logic            is_rtd,
  output logic            trim_visible
);
  function automatic logic rtd_type(input logic [7:0] t);
    return ((t >= RTD_LO_A) && (t <= RTD_HI_A)) || ((t >= RTD_LO_B) && (t <= RTD_HI_B));
  endfunction

  always_comb begin
    is_rtd       = rtd_type(range_type);
    trim_visible = is_rtd && (special_func == SFC_TRIM_ENABLE); // [RULE_01] [RULE_02]
    mode_visible = vis_mask[2:0]; // [RULE_15]
    if (!config_bits[CFG_CTRL_METHOD]) begin
      mode_visible[BIT_AM] = 1'b0; // [RULE_14]
    end
    if (!config_bits[CFG_REMOTE_CAP]) begin
      mode_visible[BIT_SPS] = 1'b0; // [RULE_16]
    end
    // contact-driven selectors stay visible but keypad cannot set them
    mode_settable = mode_visible & ~config_bits[2:0]; // [RULE_13]
  end
endmodule // mtp_access
`default_nettype wire

// [logic/mtp_trim_capture.sv]
// two-press capture sequence for the resistance trim
`default_nettype none
module mtp_trim_capture
  import mtp_pkg::*;
(
  input  wire logic               sys_clk,
  input  wire logic               reset,
  input  wire logic               enable,
  input  wire logic               enter,
  input  wire logic signed [15:0] measured_diff,
  output logic                    showing,
  output logic signed [15:0]      shown_diff,
  output logic                    store,
  output logic signed [15:0]      store_value,
  output logic                    rejected
);
  mtp_trim_state_t    state_q, state_d;
  logic signed [15:0] diff_q, diff_d;
  logic               big;

  always_comb begin
    state_d     = state_q;
    diff_d      = diff_q;
    store       = 1'b0;
    big         = (diff_q >= TRIM_LIMIT) || (diff_q <= -TRIM_LIMIT);
    store_value = big ? TRIM_RESET : diff_q; // [RULE_06]
    rejected    = 1'b0;
    if (!enable) begin
      state_d = TRIM_IDLE; // [RULE_03]
    end else if (enter) begin
      case (state_q)
        TRIM_IDLE: begin
          diff_d  = measured_diff; // [RULE_05]
          state_d = TRIM_SHOWN;
        end
        default: begin
          store    = 1'b1; // [RULE_05]
          rejected = big;
          state_d  = TRIM_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_q <= TRIM_IDLE;
      diff_q  <= TRIM_RESET;
    end else begin
      state_q <= state_d;
      diff_q  <= diff_d;
    end
  end

  assign showing    = (state_q == TRIM_SHOWN);
  assign shown_diff = diff_q;
endmodule // mtp_trim_capture
`default_nettype wire

// [logic/mtp_bank.sv]
// top: mode selectors and resistance trim behind a classic Wishbone slave
//
// What this block does
// (RULE_01) special function takes 0..15; value 5 opens the trim, else locked
// (RULE_02) trim hidden unless range is resistance-thermometer and special function is 5
// (RULE_03) no trim capture when input is not resistance-thermometer
// (RULE_04) trim spans +-20.00 ohm, resets 0.00, set only by capture
// (RULE_05) first enter shows line A-B difference, second enter stores it
// (RULE_06) difference of 20 ohm or more rejected, trim becomes 0.00
// (RULE_07) trim kept when range changes to another resistance-thermometer type
// (RULE_08) host uses barrier trim only with types 41..52 or 63..68
// (RULE_09) auto/manual: auto 0, manual 1, starts auto
// (RULE_10) any auto/manual change returns display to operation screen
// (RULE_11) run/ready: run 0, ready 1, starts run
// (RULE_12) setpoint source: local 0, remote 1, starts local
// (RULE_13) contact-assigned selector stays viewable but refuses keypad setting
// (RULE_14) on/off control hides and locks auto/manual
// (RULE_15) mask bits 0,1,2 cleared hide and lock the three selectors
// (RULE_16) no remote capability hides and locks setpoint source
// (RULE_17) auto-tuning stopped while manual or ready is in effect
// (RULE_18) writes to hidden or locked parameters are ignored
//
// The register offsets and the Wishbone slave port were chosen for this implementation.
`default_nettype none
module mtp_bank
  import mtp_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        reset,
  // wishbone classic slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // keypad
  input  wire logic        key_enter,
  input  wire logic        key_set_valid,
  input  wire logic [1:0]  key_set_sel,
  input  wire logic        key_set_value,
  // measurement side
  input  wire logic [15:0] measured_line_diff,
  // outputs
  output logic             auto_tuning_stop,
  output logic             display_to_operation,
  output logic [15:0]      trim_correction,
  output logic [2:0]       mode_state
);
  // ----------------------------------------------------------------
  // synchronisers for pin inputs
  // ----------------------------------------------------------------
  logic [4:0]  key_s1_q, key_s2_q, key_s3_q;
  logic [15:0] diff_s1_q, diff_s2_q;
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      key_s1_q  <= 5'h0;
      key_s2_q  <= 5'h0;
      key_s3_q  <= 5'h0;
      diff_s1_q <= 16'h0000;
      diff_s2_q <= 16'h0000;
    end else begin
      key_s1_q  <= {key_enter, key_set_valid, key_set_sel, key_set_value};
      key_s2_q  <= key_s1_q;
      key_s3_q  <= key_s2_q;
      diff_s1_q <= measured_line_diff;
      diff_s2_q <= diff_s1_q;
    end
  end
  // edge detect on synchronised levels only
  logic enter_pulse, set_pulse;
  assign enter_pulse = key_s2_q[4] & ~key_s3_q[4];
  assign set_pulse   = key_s2_q[3] & ~key_s3_q[3];

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic        [3:0]  sfc_q, sfc_d;
  logic        [7:0]  range_q, range_d;
  logic        [7:0]  mask_q, mask_d;
  logic        [4:0]  cfg_q, cfg_d;
  logic        [2:0]  modes_q, modes_d;
  logic signed [15:0] trim_q, trim_d;
  logic               rejected_q, rejected_d;
  logic               ack_q, ack_d;
  logic        [31:0] rdata_q, rdata_d;
  logic               disp_q, disp_d;
  logic               at_stop_q, at_stop_d;
  logic               bus_enter;

  logic [2:0] mode_visible, mode_settable;
  logic       is_rtd, trim_visible;

  mtp_access u_access (
    .range_type    (range_q),
    .special_func  (sfc_q),
    .vis_mask      (mask_q),
    .config_bits   (cfg_q),
    .mode_visible  (mode_visible),
    .mode_settable (mode_settable),
    .is_rtd        (is_rtd),
    .trim_visible  (trim_visible)
  );

  logic               cap_showing, cap_store, cap_rejected;
  logic signed [15:0] cap_shown, cap_value;

  mtp_trim_capture u_capture (
    .sys_clk       (sys_clk),
    .reset         (reset),
    .enable        (trim_visible), // [RULE_03]
    .enter         (enter_pulse | bus_enter),
    .measured_diff (diff_s2_q),
    .showing       (cap_showing),
    .shown_diff    (cap_shown),
    .store         (cap_store),
    .store_value   (cap_value),
    .rejected      (cap_rejected)
  );

  // ----------------------------------------------------------------
  // bus decode and next state
  // ----------------------------------------------------------------
  logic req, wr, rd;
  assign req = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wr  = req & wb_we_i & wb_sel_i[0];
  assign rd  = req & ~wb_we_i;
  assign bus_enter = wr && (wb_adr_i == REG_TRIM_CTRL) && wb_dat_i[TCTL_ENTER];

  always_comb begin
    sfc_d      = sfc_q;
    range_d    = range_q;
    mask_d     = mask_q;
    cfg_d      = cfg_q;
    modes_d    = modes_q;
    trim_d     = trim_q;
    rejected_d = rejected_q;
    ack_d      = req;
    rdata_d    = 32'h0000_0000;
    // writes
    if (wr) begin
      if (wb_adr_i == REG_SPECIAL_FUNC) begin
        sfc_d = wb_dat_i[3:0]; // [RULE_01]
      end else if (wb_adr_i == REG_RANGE_TYPE) begin
        range_d = wb_dat_i[7:0]; // trim untouched [RULE_07]
      end else if (wb_adr_i == REG_VIS_MASK) begin
        mask_d = wb_dat_i[7:0];
      end else if (wb_adr_i == REG_CONFIG) begin
        cfg_d = wb_dat_i[4:0];
      end else if (wb_adr_i == REG_MODES) begin
        // host may set visible selectors; hidden ones keep value
        for (int i = 0; i < 3; i++) begin
          if (mode_visible[i]) begin
            modes_d[i] = wb_dat_i[i]; // [RULE_09] [RULE_11] [RULE_12] [RULE_18]
          end
        end
      end
      // trim register is read-only: no direct entry [RULE_04]
    end
    // keypad set, refused when locked
    if (set_pulse && (key_s2_q[2:1] != 2'd3) && mode_settable[key_s2_q[2:1]]) begin
      modes_d[key_s2_q[2:1]] = key_s2_q[0]; // [RULE_13] [RULE_18]
    end
    if (cap_store) begin
      trim_d     = cap_value; // [RULE_05] [RULE_06]
      rejected_d = cap_rejected;
    end
    // reads
    if (rd) begin
      if (wb_adr_i == REG_SPECIAL_FUNC) begin
        rdata_d = {28'h000_0000, sfc_q};
      end else if (wb_adr_i == REG_RANGE_TYPE) begin
        rdata_d = {24'h00_0000, range_q};
      end else if (wb_adr_i == REG_VIS_MASK) begin
        rdata_d = {24'h00_0000, mask_q};
      end else if (wb_adr_i == REG_CONFIG) begin
        rdata_d = {27'h000_0000, cfg_q};
      end else if (wb_adr_i == REG_MODES) begin
        rdata_d = {29'h0000_0000, modes_q & mode_visible}; // hidden reads zero
      end else if (wb_adr_i == REG_TRIM) begin
        if (trim_visible) begin
          // -20.00 displays as -19.99
          rdata_d = {16'h0000, (trim_q < TRIM_SHOWN_MIN) ? TRIM_SHOWN_MIN : trim_q};
        end
      end else if (wb_adr_i == REG_STATUS) begin
        rdata_d = {12'h000, cap_shown, rejected_q, cap_showing, is_rtd, trim_visible};
      end
    end
    // outputs
    disp_d    = (modes_d[BIT_AM] != modes_q[BIT_AM]); // [RULE_10]
    at_stop_d = modes_q[BIT_AM] | modes_q[BIT_RR]; // [RULE_17]
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sfc_q      <= SFC_RESET; // power-on clears special function
      range_q    <= RANGE_RESET;
      mask_q     <= VIS_MASK_RESET;
      cfg_q      <= CONFIG_RESET;
      modes_q    <= MODES_RESET; // [RULE_09] [RULE_11] [RULE_12]
      trim_q     <= TRIM_RESET; // [RULE_04]
      rejected_q <= 1'b0;
      ack_q      <= 1'b0;
      rdata_q    <= 32'h0000_0000;
      disp_q     <= 1'b0;
      at_stop_q  <= 1'b0;
    end else begin
      sfc_q      <= sfc_d;
      range_q    <= range_d;
      mask_q     <= mask_d;
      cfg_q      <= cfg_d;
      modes_q    <= modes_d;
      trim_q     <= trim_d;
      rejected_q <= rejected_d;
      ack_q      <= ack_d;
      rdata_q    <= rdata_d;
      disp_q     <= disp_d;
      at_stop_q  <= at_stop_d;
    end
  end

  // trim_correction, mode_state mirror flops directly
  assign wb_ack_o             = ack_q;
  assign wb_dat_o             = rdata_q;
  assign display_to_operation = disp_q;
  assign auto_tuning_stop     = at_stop_q;
  assign trim_correction      = trim_q; // [RULE_07]
  assign mode_state           = modes_q;
endmodule // mtp_bank
`default_nettype wire

// [tb/mtp_bank_assertions.sv]
// checker: port-level properties of the mode and trim bank
`default_nettype none
module mtp_bank_assertions
  import mtp_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        reset,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        key_set_valid,
  input wire logic        auto_tuning_stop,
  input wire logic        display_to_operation,
  input wire logic [15:0] trim_correction,
  input wire logic [2:0]  mode_state
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  // ----------------------------------------
  // bus handshake, mode and trim outputs
  // ----------------------------------------
  a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_answers: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered next cycle");
  a_idle_data_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data not zero outside ack");
  a_unmapped_zero: assert property (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o
    && wb_adr_i > REG_STATUS |=> wb_dat_o == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_tune_stop_mode: assert property (
    1'h1 |=> auto_tuning_stop == $past(mode_state[BIT_AM] | mode_state[BIT_RR]))
    else $error("tuning stop does not follow modes");
  a_disp_on_am: assert property (
    $changed(mode_state[BIT_AM]) |-> ##[0:1] display_to_operation)
    else $error("no return to operation screen");
  a_trim_in_range: assert property (
    $signed(trim_correction) < TRIM_LIMIT && $signed(trim_correction) > -TRIM_LIMIT)
    else $error("trim outside its span");
  // keypad holds valid six cycles, so a keypad change sees it 1..3 cycles back, covering 2 and 3 of the 2..4 checked
  a_mode_needs_cause: assert property ($changed(mode_state) |-> wb_ack_o
    || $past(key_set_valid, 2) || $past(key_set_valid, 3) || $past(key_set_valid, 4))
    else $error("mode changed without a request");
endmodule // mtp_bank_assertions
`default_nettype wire

// [tb/mtp_keypad.sv]
// partner: front-panel keypad and line-resistance source
`default_nettype none
module mtp_keypad (
  input  wire logic        sys_clk,
  output var logic         key_enter,
  output var logic         key_set_valid,
  output var logic [1:0]   key_set_sel,
  output var logic         key_set_value,
  output var logic [15:0]  measured_line_diff
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    key_enter = 1'h0;
    key_set_valid = 1'h0;
    key_set_sel = 2'h3;
    key_set_value = 1'h0;
    measured_line_diff = 16'h0000;
  end
  // held six cycles: the design sees presses through two sync flops
  task automatic press;
    @(posedge sys_clk);
    key_enter <= 1'h1;
    repeat (6) @(posedge sys_clk);
    key_enter <= 1'h0;
    repeat (6) @(posedge sys_clk);
  endtask
  task automatic set_mode(input logic [1:0] s, input logic v);
    @(posedge sys_clk);
    key_set_sel <= s;
    key_set_value <= v;
    repeat (4) @(posedge sys_clk);
    key_set_valid <= 1'h1;
    repeat (6) @(posedge sys_clk);
    key_set_valid <= 1'h0;
    key_set_sel <= 2'h3;
    key_set_value <= ~v;
    repeat (6) @(posedge sys_clk);
  endtask
  task automatic set_diff(input logic [15:0] d);
    @(posedge sys_clk);
    measured_line_diff <= d;
    repeat (4) @(posedge sys_clk);
  endtask
endmodule // mtp_keypad
`default_nettype wire

// [tb/tb.sv]
// testbench: register, keypad and trim capture sequences for the bank
`default_nettype none
module tb;
  import mtp_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk = 1'h0;
  logic        reset = 1'h1;
  logic        wb_cyc_i = 1'h0;
  logic        wb_stb_i = 1'h0;
  logic        wb_we_i = 1'h0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o, q;
  logic        wb_ack_o, key_enter, key_set_valid, key_set_value;
  logic        auto_tuning_stop, display_to_operation;
  logic [1:0]  key_set_sel;
  logic [15:0] measured_line_diff, trim_correction;
  logic [2:0]  mode_state;
  int          errors = 0;
  int          n_compared = 0;
  int          n_disp = 0;
  always #5 sys_clk = ~sys_clk;
  // screen-return pulses stand one cycle, so count them as they pass
  always @(posedge sys_clk) begin
    if (display_to_operation === 1'h1) begin
      n_disp <= n_disp + 1;
    end
  end
  mtp_bank mtp_bank_i (.sys_clk, .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .key_enter, .key_set_valid, .key_set_sel,
    .key_set_value, .measured_line_diff, .auto_tuning_stop, .display_to_operation,
    .trim_correction, .mode_state);
  mtp_keypad kp_i (.sys_clk, .key_enter, .key_set_valid, .key_set_sel, .key_set_value,
    .measured_line_diff);
  task automatic end_of_test;
    if (errors == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // request held until ack is sampled high at a rising edge, then released there
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge sys_clk);
      n++;
    end while (wb_ack_o !== 1'h1 && n < 20);
    if (n >= 20) begin
      chk({31'h0, wb_ack_o}, 32'h0000_0001);
      end_of_test();
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    wb(1'h0, a, 32'h0000_0000);
    chk(q, exp);
  endtask
  task automatic chk_trim(input logic [31:0] exp);
    repeat (4) @(posedge sys_clk);
    chk({16'h0000, trim_correction}, exp);
  endtask
  initial begin
    repeat (8) @(posedge sys_clk);
    reset <= 1'h0;
    rd(REG_SPECIAL_FUNC, 32'h0000_0000);
    rd(REG_VIS_MASK, 32'h0000_00FF);
    rd(REG_MODES, 32'h0000_0000);
    rd(REG_TRIM, 32'h0000_0000);
    rd(8'h40, 32'h0000_0000);
    wb(1'h1, REG_MODES, 32'h0000_0007);
    rd(REG_MODES, 32'h0000_0003);
    chk({31'h0, auto_tuning_stop}, 32'h0000_0001);
    wb(1'h1, REG_CONFIG, 32'h0000_0010);
    wb(1'h1, REG_MODES, 32'h0000_0000);
    rd(REG_MODES, 32'h0000_0000);
    chk({29'h0, mode_state}, 32'h0000_0001);
    wb(1'h1, REG_CONFIG, 32'h0000_0018);
    wb(1'h1, REG_MODES, 32'h0000_0000);
    @(posedge sys_clk); // stop flag lags the mode bits by a cycle
    chk({31'h0, auto_tuning_stop}, 32'h0000_0000);
    for (int b = 0; b < 3; b++) begin
      wb(1'h1, REG_VIS_MASK, 32'h0000_00FF ^ (32'h0000_0001 << b));
      wb(1'h1, REG_MODES, 32'h0000_0007);
      rd(REG_MODES, 32'h0000_0007 ^ (32'h0000_0001 << b));
      wb(1'h1, REG_VIS_MASK, 32'h0000_00FF);
      wb(1'h1, REG_MODES, 32'h0000_0000);
      wb(1'h1, REG_CONFIG, 32'h0000_0018 | (32'h0000_0001 << b));
      kp_i.set_mode(2'(b), 1'h1);
      rd(REG_MODES, 32'h0000_0000);
      wb(1'h1, REG_CONFIG, 32'h0000_0018);
      kp_i.set_mode(2'(b), 1'h1);
      rd(REG_MODES, 32'h0000_0001 << b);
      wb(1'h1, REG_MODES, 32'h0000_0000);
    end
    wb(1'h1, REG_RANGE_TYPE, 32'h0000_001E);
    chk(n_disp, 32'h0000_0008);
    wb(1'h1, REG_SPECIAL_FUNC, 32'h0000_0005);
    rd(REG_STATUS, 32'h0000_0000);
    kp_i.set_diff(16'h04D2);
    kp_i.press();
    kp_i.press();
    chk_trim(32'h0000_0000);
    wb(1'h1, REG_RANGE_TYPE, 32'h0000_0029);
    wb(1'h1, REG_SPECIAL_FUNC, 32'h0000_0003);
    rd(REG_STATUS, 32'h0000_0002);
    wb(1'h1, REG_SPECIAL_FUNC, 32'h0000_0005);
    rd(REG_STATUS, 32'h0000_0003);
    kp_i.press();
    rd(REG_STATUS, 32'h0000_4D27);
    wb(1'h1, REG_TRIM_CTRL, 32'h0000_0001);
    chk_trim(32'h0000_04D2);
    wb(1'h1, REG_TRIM, 32'h0000_0100);
    rd(REG_TRIM, 32'h0000_04D2);
    wb(1'h1, REG_RANGE_TYPE, 32'h0000_003F);
    chk_trim(32'h0000_04D2);
    kp_i.set_diff(16'h07D0);
    kp_i.press();
    kp_i.press();
    chk_trim(32'h0000_0000);
    end_of_test();
  end
  // whole run needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    end_of_test();
  end
endmodule // tb
bind mtp_bank mtp_bank_assertions mtp_bank_assertions_i (.sys_clk, .reset, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .key_set_valid, .auto_tuning_stop,
  .display_to_operation, .trim_correction, .mode_state);
`default_nettype wire
